// ==== hdl/acp_port.sv ====
// serial conversion port: convert strobe, config shift-in, result shift-out
module acp_port
    import acp_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire acp_pins_s i_pins,
    input wire logic [RES_BITS-1:0] i_sample_code,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic [CFG_BITS-1:0] o_config,
    output logic o_converting
);
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    acp_edge_sync #(.W(3)) u_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_async({i_pins.convert_strobe, i_pins.sck, i_pins.sdi}),
        .o_level(pin_lvl),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    wire strobe_hi = pin_lvl[2];
    wire strobe_rise = pin_rise[2];
    wire sck_rise = pin_rise[1];
    wire sck_fall = pin_fall[1];
    wire sdi = pin_lvl[0];

    logic converting;
    logic [$clog2(CONV_LEN+1)-1:0] conv_cnt;
    logic busy_arm;
    logic [RES_BITS-1:0] res_shift;
    logic [3:0] rd_cnt;
    logic [CFG_BITS-1:0] cfg_shift;
    logic [3:0] wr_cnt;
    logic [CFG_BITS-1:0] cfg;

    // conversion runs on the internal clock only; sck never touches it
    wire conv_done = converting && (conv_cnt == 1) && !strobe_rise;
    wire bipolar = cfg[CFG_BIPOLAR_POS];
    // offset binary from the array becomes two's complement by flipping the msb
    wire [RES_BITS-1:0] coded = bipolar ? (i_sample_code ^ BIPOLAR_FLIP) : i_sample_code;
    wire read_phase = !strobe_hi && (rd_cnt != BITS_DONE);
    wire shift_out = read_phase && sck_fall;
    // writes are gated by strobe and the word count, not by conversion state
    wire shift_in = !strobe_hi && sck_rise && (wr_cnt != BITS_DONE);
    wire cfg_load = shift_in && (wr_cnt == CFG_LAST);
    wire busy_mode = strobe_hi && (converting || busy_arm);

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            converting <= 1'b0;
            conv_cnt <= '0;
        end else if (strobe_rise) begin
            converting <= 1'b1;
            conv_cnt <= ($bits(conv_cnt))'(CONV_LEN);
        end else if (converting) begin
            conv_cnt <= conv_cnt - 1'b1;
            converting <= !conv_done;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_arm <= 1'b0;
        end else begin
            busy_arm <= strobe_hi && (converting || busy_arm);
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_shift <= RES_RESET;
            rd_cnt <= BITS_DONE;
        end else if (conv_done) begin
            res_shift <= coded;
            rd_cnt <= '0;
        end else if (shift_out) begin
            res_shift <= {res_shift[RES_BITS-2:0], 1'b0};
            rd_cnt <= rd_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_shift <= '0;
            wr_cnt <= '0;
        end else if (strobe_rise) begin
            wr_cnt <= '0;
        end else if (shift_in) begin
            cfg_shift <= {cfg_shift[CFG_BITS-2:0], sdi};
            wr_cnt <= wr_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_RESET;
        end else if (cfg_load) begin
            cfg <= {cfg_shift[CFG_BITS-2:0], sdi};
        end
    end

    // busy drives high until done, then low until the strobe drops
    assign o_sdo_oe = busy_mode || read_phase;
    assign o_sdo = busy_mode ? converting : (read_phase & res_shift[RES_BITS-1]);
    assign o_config = cfg;
    assign o_converting = converting;

    sequence s_start;
        strobe_rise;
    endsequence
    sequence s_running;
        converting [*8];
    endsequence

    property p_start;
        @(posedge i_clk) disable iff (!rst_n) s_start |=> s_running;
    endproperty
    a_start: assert property (p_start) else $error("conversion did not start on strobe edge");

    property p_busy;
        @(posedge i_clk) disable iff (!rst_n) (converting && strobe_hi) |-> (o_sdo_oe && o_sdo);
    endproperty
    a_busy: assert property (p_busy) else $error("busy indication missing");

    property p_cfg_load;
        @(posedge i_clk) disable iff (!rst_n) cfg_load |=> (cfg == {$past(cfg_shift[CFG_BITS-2:0]), $past(sdi)});
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("config word not captured");

    property p_cfg_in_conv;
        @(posedge i_clk) disable iff (!rst_n)
            (converting && !strobe_hi && sck_rise && wr_cnt < BITS_DONE) |=> (wr_cnt == $past(wr_cnt) + 4'h1);
    endproperty
    a_cfg_in_conv: assert property (p_cfg_in_conv) else $error("config write refused during conversion");

    property p_msb_order;
        @(posedge i_clk) disable iff (!rst_n)
            (shift_out && !conv_done && rd_cnt < CFG_LAST) |=> (o_sdo == $past(res_shift[RES_BITS-2]));
    endproperty
    a_msb_order: assert property (p_msb_order) else $error("result not shifted msb first");

    property p_read_drive;
        @(posedge i_clk) disable iff (!rst_n) (!strobe_hi && rd_cnt < BITS_DONE) |-> (o_sdo_oe && o_sdo == res_shift[13]);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("result bit not driven");

    property p_coding;
        @(posedge i_clk) disable iff (!rst_n)
            conv_done |=> (res_shift == ($past(bipolar) ? ($past(i_sample_code) ^ BIPOLAR_FLIP) : $past(i_sample_code)));
    endproperty
    a_coding: assert property (p_coding) else $error("result coding wrong");

    property p_float;
        @(posedge i_clk) disable iff (!rst_n) (!strobe_hi && rd_cnt == BITS_DONE) |-> !o_sdo_oe;
    endproperty
    a_float: assert property (p_float) else $error("sdo driven outside transfer");

    property p_sck_no_timing;
        @(posedge i_clk) disable iff (!rst_n)
            (converting && conv_cnt > 1 && !strobe_rise) |=> (conv_cnt == $past(conv_cnt) - 1'b1);
    endproperty
    a_sck_no_timing: assert property (p_sck_no_timing) else $error("conversion timing disturbed");
endmodule

// ==== hdl/acp_pkg.sv ====
// shared constants and pin bundle for the converter serial port
package acp_pkg;
    localparam int RES_BITS = 14;
    localparam int CFG_BITS = 14;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 2200;
    // longest time rounds down to whole cycles
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CFG_BIPOLAR_POS = 13;
    localparam logic [13:0] CFG_RESET = 14'h3FFF;
    localparam logic [13:0] RES_RESET = 14'h0000;
    localparam logic [13:0] BIPOLAR_FLIP = 14'h2000;
    localparam logic [3:0] BITS_DONE = 4'hE;
    localparam logic [3:0] CFG_LAST = 4'hD;

    typedef struct packed {
        logic convert_strobe;
        logic sck;
        logic sdi;
    } acp_pins_s;
endpackage

// ==== hdl/acp_edge_sync.sv ====
// two-flop synchroniser with edge pulses, one lane per bit
module acp_edge_sync #(
    parameter int W = 3
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level,
    output logic [W-1:0] o_rise,
    output logic [W-1:0] o_fall
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_lane
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta[g] <= 1'b0;
                    stable[g] <= 1'b0;
                    prev[g] <= 1'b0;
                end else begin
                    meta[g] <= i_async[g];
                    stable[g] <= meta[g];
                    prev[g] <= stable[g];
                end
            end
            assign o_rise[g] = stable[g] & ~prev[g];
            assign o_fall[g] = ~stable[g] & prev[g];
        end
    endgenerate

    assign o_level = stable;
endmodule

// ==== dv/acp_host.sv ====
// host controller model: convert strobe, serial clock, config and result frames
module acp_host
    import acp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output acp_pins_s o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_pins = '0;
    logic last_bit = 1'b0;
    // a released sdo shows the inverse of its last driven bit, so an early release reads wrong
    always @(posedge i_clk)
        if (i_sdo_oe)
            last_bit <= i_sdo;
    wire logic line = i_sdo_oe ? i_sdo : ~last_bit;
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic strobe(input logic lvl);
        @(posedge i_clk) o_pins.convert_strobe <= lvl;
    endtask
    // sck stands still outside frames; 80 ns a bit, sdi moves with the fall and is taken on the rise
    task automatic frame(input logic [CFG_BITS-1:0] w, output logic [RES_BITS-1:0] r);
        for (int k = CFG_BITS - 1; k >= 0; k--) begin
            @(posedge i_clk) begin
                o_pins.sck <= 1'b0;
                o_pins.sdi <= w[k];
            end
            wait_clk(4);
            r[k] = line;
            o_pins.sck <= 1'b1;
            wait_clk(3);
        end
        // sdi is left at the inverse of its last bit, sck low
        @(posedge i_clk) begin
            o_pins.sck <= 1'b0;
            o_pins.sdi <= ~w[0];
        end
    endtask
endmodule

// ==== dv/test_adc_serial_conversion_port.sv ====
// self-checking bench for the converter serial port
module test_adc_serial_conversion_port
    import acp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LEN = 200;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [RES_BITS-1:0] code = 14'h0000;
    logic [RES_BITS-1:0] r;
    acp_pins_s pins;
    logic sdo;
    logic oe;
    logic [CFG_BITS-1:0] cfg;
    logic conv;
    int errors = 0;
    int comparisons = 0;
    initial forever #5 clk = ~clk;
    acp_host host_u (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(oe), .o_pins(pins));
    acp_port #(.CONV_LEN(LEN)) dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_pins(pins), .i_sample_code(code),
        .o_sdo(sdo), .o_sdo_oe(oe), .o_config(cfg), .o_converting(conv));
    task automatic stop_test();
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_conv(input logic lvl);
        int n;
        n = 0;
        while (conv !== lvl && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            errors++;
            stop_test();
        end
    endtask
    // short pulse: the strobe is back low before the conversion ends, so busy is driven only briefly at the start
    task automatic start(input logic [13:0] c);
        @(posedge clk) code <= c;
        host_u.strobe(1'b1);
        host_u.wait_clk(2);
        host_u.strobe(1'b0);
        wait_conv(1'b1);
    endtask
    task automatic t_reset();
        check("config", CFG_RESET, cfg);
        check("oe", 14'h0000, oe);
        check("converting", 14'h0000, conv);
    endtask
    task automatic t_write_during_and_after();
        start(14'h2AAA);
        host_u.frame(14'h0ABC, r);
        host_u.wait_clk(5);
        check("still converting", 14'h0001, conv);
        check("config during", 14'h0ABC, cfg);
        wait_conv(1'b0);
        host_u.wait_clk(4);
        // one word per conversion cycle: a second word before the next strobe is refused
        host_u.frame(14'h3FFF, r);
        check("unipolar result", 14'h2AAA, r);
        check("config kept", 14'h0ABC, cfg);
        start(14'h1555);
        wait_conv(1'b0);
        host_u.wait_clk(4);
        host_u.frame(14'h2ABC, r);
        check("second result", 14'h1555, r);
        host_u.wait_clk(4);
        check("oe after frame", 14'h0000, oe);
        check("config after", 14'h2ABC, cfg);
    endtask
    task automatic t_restart_bipolar();
        start(14'h0000);
        host_u.wait_clk(50);
        start(14'h3FFF);
        host_u.wait_clk(LEN - 10);
        check("restarted", 14'h0001, conv);
        wait_conv(1'b0);
        host_u.wait_clk(4);
        host_u.frame(14'h0ABC, r);
        check("bipolar result", 14'h3FFF ^ BIPOLAR_FLIP, r);
    endtask
    task automatic t_busy();
        host_u.strobe(1'b1);
        wait_conv(1'b1);
        host_u.wait_clk(2);
        check("busy oe", 14'h0001, oe);
        check("busy level", 14'h0001, sdo);
        wait_conv(1'b0);
        check("busy done oe", 14'h0001, oe);
        check("busy done level", 14'h0000, sdo);
        host_u.strobe(1'b0);
        host_u.wait_clk(6);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset();
        t_write_during_and_after();
        t_restart_bipolar();
        t_busy();
        stop_test();
    end
endmodule
